// ### logic/power_clock_consts.vh
// Purpose: Constants for the power-mode and core-clock control block
// Assumes: 100 MHz system clock, 32-bit memory-mapped register port
// Notes:   Definitions only; included by bare name
//
// Summary of operation
// - Bit 7 enables precision input with HV enable
// - Bit 6 enables watch-crystal circuitry
// - Bit 5 resets set, wake sets, loop stops once bits 5, 4 and 3 are all clear
// - Loop-clocked timers stop with loop
// - Bit 4 powers peripherals, wake sets it
// - Wake-up timer runs on low-power oscillator
// - LIN wake detection survives peripheral power-down
// - Bit 3 powers core, wake sets it
// - Bits 2-0 divide loop clock by 2^n
// - Divide field resets to 001
// - Prewrite and postwrite keys guard updates
`ifndef POWER_CLOCK_CONSTS_VH
`define POWER_CLOCK_CONSTS_VH

`define PWR_CTRL_ADDR        32'hffff0408
`define PWR_PREKEY_ADDR      32'hffff0404
`define PWR_POSTKEY_ADDR     32'hffff040c

`define PWR_PREKEY_VALUE     32'h00000001
`define PWR_POSTKEY_VALUE    32'h000000f4

`define PWR_CTRL_RESET       8'h79

`define PWR_BIT_PREC_IN      7
`define PWR_BIT_XTAL         6
`define PWR_BIT_PLL          5
`define PWR_BIT_PERIPH       4
`define PWR_BIT_CORE         3
`define PWR_CD_MSB           2
`define PWR_CD_LSB           0
`define PWR_CD_RESET         3'h1

`define PWR_DIV_CNT_W        7
`define PWR_TIMER_CNT        3
`define PWR_WAKE_TIMER_IDX   2

`endif

// ### logic/power_key_sequencer.v
// Purpose: Keyed-write sequencer for the power control register
// Assumes: One bus write per cycle at most
// Notes:   Any off-sequence write drops back to idle
`timescale 1ns/1ps
`default_nettype none
`include "power_clock_consts.vh"

module power_key_sequencer (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Decoded bus write
  input  wire        wr_i,
  input  wire        prekey_hit_i,
  input  wire        ctrl_hit_i,
  input  wire        postkey_hit_i,
  input  wire [31:0] wdata_i,
  // Accepted update
  output reg         commit_o,
  output reg  [7:0]  commit_data_o,
  output reg  [1:0]  state_o
);

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_ARMED = 2'h1;
  localparam [1:0] ST_HELD  = 2'h2;

  reg [1:0] next_state;

  always @* begin
    next_state = state_o;
    if (wr_i) begin
      case (state_o)
        ST_IDLE: begin
          if (prekey_hit_i && wdata_i == `PWR_PREKEY_VALUE) next_state = ST_ARMED;
        end
        ST_ARMED: begin
          if (ctrl_hit_i) next_state = ST_HELD;
          else next_state = ST_IDLE;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_o       <= ST_IDLE;
      commit_o      <= 1'b0;
      commit_data_o <= 8'h00;
    end else begin
      state_o  <= next_state;
      // Only a correct postwrite key right after the data write commits
      commit_o <= wr_i && state_o == ST_HELD && postkey_hit_i &&
                  wdata_i == `PWR_POSTKEY_VALUE;
      if (wr_i && state_o == ST_ARMED && ctrl_hit_i) begin
        commit_data_o <= wdata_i[7:0];
      end
    end
  end

endmodule // power_key_sequencer
`default_nettype wire

// ### logic/core_clock_divider.v
// Purpose: Core clock enable from loop-clock ticks divided by 2^n
// Assumes: loop_tick_i pulses once per 20.48 MHz loop cycle
// Notes:   Ratio changes take effect at once; the count is masked by the new limit
`timescale 1ns/1ps
`default_nettype none
`include "power_clock_consts.vh"

module core_clock_divider (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_n_i,
  // Control
  input  wire       run_i,
  input  wire       loop_tick_i,
  input  wire [2:0] divide_i,
  // Output
  output reg        core_tick_o
);

  reg [`PWR_DIV_CNT_W-1:0] count;
  reg [`PWR_DIV_CNT_W-1:0] limit;

  always @* begin
    limit = (7'h01 << divide_i) - 7'h01;
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count       <= {`PWR_DIV_CNT_W{1'b0}};
      core_tick_o <= 1'b0;
    end else begin
      core_tick_o <= 1'b0;
      if (!run_i) begin
        count <= {`PWR_DIV_CNT_W{1'b0}};
      end else if (loop_tick_i) begin
        if ((count & limit) == limit) begin
          count       <= {`PWR_DIV_CNT_W{1'b0}};
          core_tick_o <= 1'b1;
        end else begin
          count <= count + 7'h01;
        end
      end
    end
  end

endmodule // core_clock_divider
`default_nettype wire

// ### logic/power_clock_control.v
// Purpose: Power-mode and core-clock control register with its effects
// Assumes: Memory-mapped register port synchronous to clk_i
// Notes:   Domain enables are registered; outputs lag a commit by two cycles
`timescale 1ns/1ps
`default_nettype none
`include "power_clock_consts.vh"

module power_clock_control (
  // Clock and reset
  input  wire                        clk_i,
  input  wire                        rst_n_i,
  // Register port
  input  wire [31:0]                 addr_i,
  input  wire [31:0]                 wdata_i,
  input  wire                        wr_i,
  input  wire                        rd_i,
  output reg  [31:0]                 rdata_o,
  // Wake-up and oscillator inputs
  input  wire                        wakeup_i,
  input  wire                        high_voltage_config_i,
  input  wire                        loop_tick_i,
  // Timer clock sources
  input  wire [`PWR_TIMER_CNT-1:0]   timer_src_loop_i,
  input  wire                        wakeup_timer_lp_osc_i,
  // Oscillator and loop enables
  output reg                         precision_input_en_o,
  output reg                         xtal_en_o,
  output reg                         pll_en_o,
  // Domain enables
  output reg                         core_en_o,
  output reg                         sram_en_o,
  output reg                         flash_if_en_o,
  output reg                         gpio_en_o,
  output reg                         spi_en_o,
  output reg                         uart_en_o,
  output reg                         lin_wake_en_o,
  // Timers
  output reg  [`PWR_TIMER_CNT-1:0]   timer_run_o,
  // Core clock
  output reg                         core_clk_en_o,
  output reg  [2:0]                  core_clock_divide_o
);

  // Address match helper shared by read and write decode
  function addr_is;
    input [31:0] a;
    input [31:0] b;
    begin
      addr_is = (a == b);
    end
  endfunction

  reg  [7:0]                power_clock_control;
  reg  [7:0]                next_ctrl;
  reg  [31:0]               next_rdata;
  reg  [`PWR_TIMER_CNT-1:0] next_timer_run;
  reg                       next_pll_en;
  reg                       next_periph_en;
  reg                       next_core_en;

  wire                      prekey_hit;
  wire                      ctrl_hit;
  wire                      postkey_hit;
  wire                      commit;
  wire [7:0]                commit_data;
  wire [1:0]                key_state;
  wire                      core_tick;

  assign prekey_hit  = addr_is(addr_i, `PWR_PREKEY_ADDR);
  assign ctrl_hit    = addr_is(addr_i, `PWR_CTRL_ADDR);
  assign postkey_hit = addr_is(addr_i, `PWR_POSTKEY_ADDR);

  power_key_sequencer u_keys (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .wr_i          (wr_i),
    .prekey_hit_i  (prekey_hit),
    .ctrl_hit_i    (ctrl_hit),
    .postkey_hit_i (postkey_hit),
    .wdata_i       (wdata_i),
    .commit_o      (commit),
    .commit_data_o (commit_data),
    .state_o       (key_state)
  );

  // Register update: a wake-up sets bits 5, 4 and 3 even when a commit in the same cycle clears them
  always @* begin
    next_ctrl = power_clock_control;
    if (commit) begin
      next_ctrl = commit_data;
    end
    if (wakeup_i) begin
      next_ctrl[`PWR_BIT_PLL]    = 1'b1;
      next_ctrl[`PWR_BIT_PERIPH] = 1'b1;
      next_ctrl[`PWR_BIT_CORE]   = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      power_clock_control <= `PWR_CTRL_RESET;
    end else begin
      power_clock_control <= next_ctrl;
    end
  end

  // Effective domain enables
  always @* begin
    next_core_en   = power_clock_control[`PWR_BIT_CORE];
    // Peripherals cannot drop while the core still runs
    next_periph_en = power_clock_control[`PWR_BIT_PERIPH] |
                     power_clock_control[`PWR_BIT_CORE];
    // Loop stays up while either dependent domain is on
    next_pll_en    = power_clock_control[`PWR_BIT_PLL] |
                     power_clock_control[`PWR_BIT_PERIPH] |
                     power_clock_control[`PWR_BIT_CORE];
  end

  // Timers on a stopped loop clock halt, others keep running
  always @* begin
    next_timer_run = ~timer_src_loop_i | {`PWR_TIMER_CNT{next_pll_en}};
    if (wakeup_timer_lp_osc_i) begin
      next_timer_run[`PWR_WAKE_TIMER_IDX] = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      precision_input_en_o <= 1'b0;
      xtal_en_o            <= 1'b1;
      pll_en_o             <= 1'b1;
      core_en_o            <= 1'b1;
      sram_en_o            <= 1'b1;
      flash_if_en_o        <= 1'b1;
      gpio_en_o            <= 1'b1;
      spi_en_o             <= 1'b1;
      uart_en_o            <= 1'b1;
      lin_wake_en_o        <= 1'b0;
      timer_run_o          <= {`PWR_TIMER_CNT{1'b1}};
      core_clock_divide_o  <= `PWR_CD_RESET;
    end else begin
      // Input only live when the high-voltage configuration is also enabled
      precision_input_en_o <= power_clock_control[`PWR_BIT_PREC_IN] &
                              high_voltage_config_i;
      xtal_en_o            <= power_clock_control[`PWR_BIT_XTAL];
      pll_en_o             <= next_pll_en;
      core_en_o            <= next_core_en;
      sram_en_o            <= next_periph_en;
      flash_if_en_o        <= next_periph_en;
      gpio_en_o            <= next_periph_en;
      spi_en_o             <= next_periph_en;
      uart_en_o            <= next_periph_en;
      // Wake detection is independent of the peripheral domain
      lin_wake_en_o        <= 1'b1;
      timer_run_o          <= next_timer_run;
      core_clock_divide_o  <= power_clock_control[`PWR_CD_MSB:`PWR_CD_LSB];
    end
  end

  core_clock_divider u_div (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .run_i       (next_pll_en & next_core_en),
    .loop_tick_i (loop_tick_i),
    .divide_i    (power_clock_control[`PWR_CD_MSB:`PWR_CD_LSB]),
    .core_tick_o (core_tick)
  );

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_clk_en_o <= 1'b0;
    end else begin
      core_clk_en_o <= core_tick;
    end
  end

  // Read path; key registers are write-only and read as zero
  always @* begin
    next_rdata = 32'h00000000;
    if (rd_i) begin
      if (ctrl_hit) begin
        next_rdata = {24'h000000, power_clock_control};
      end else begin
        next_rdata = 32'h00000000;
      end
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule // power_clock_control
`default_nettype wire

// ### verif/power_clock_monitor.sv
// Purpose: Assertion checker for power_clock_control
// Assumes: Bound to the top module; sees its ports only
// Notes:   Enables lag the control register by one cycle
`timescale 1ns/1ps
`default_nettype none
module power_clock_monitor (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [31:0] addr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic        wakeup_i,
  input wire logic        high_voltage_config_i,
  input wire logic [2:0]  timer_src_loop_i,
  input wire logic        wakeup_timer_lp_osc_i,
  input wire logic        precision_input_en_o,
  input wire logic        pll_en_o,
  input wire logic        core_en_o,
  input wire logic        sram_en_o,
  input wire logic        flash_if_en_o,
  input wire logic        gpio_en_o,
  input wire logic        spi_en_o,
  input wire logic        uart_en_o,
  input wire logic [2:0]  timer_run_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  other_read_a:
    assert property (rd_i && addr_i != 32'hffff0408 |=> rdata_o == 32'h0) else $error("nonzero read");
  precision_gate_a:
    assert property (precision_input_en_o |-> $past(high_voltage_config_i)) else $error("precision ungated");
  wake_sets_a:
    assert property (wakeup_i |-> ##2 (core_en_o && pll_en_o && sram_en_o)) else $error("wake missed");
  pll_dep_a:
    assert property ((core_en_o || sram_en_o) |-> pll_en_o) else $error("loop off too early");
  periph_dep_a:
    assert property (core_en_o |-> sram_en_o && flash_if_en_o) else $error("periph off with core");
  periph_group_a:
    assert property ({flash_if_en_o, gpio_en_o, spi_en_o, uart_en_o} == {4{sram_en_o}}) else $error("periph split");
  loop_timer_a:
    assert property (!pll_en_o && !$past(pll_en_o) && $past(timer_src_loop_i[0]) |-> !timer_run_o[0])
      else $error("loop timer runs");
  lp_timer_a:
    assert property ($past(wakeup_timer_lp_osc_i) |-> timer_run_o[2]) else $error("wake timer stopped");
endmodule // power_clock_monitor

bind power_clock_control power_clock_monitor u_power_clock_monitor (.clk_i, .rst_n_i, .addr_i, .rd_i,
  .rdata_o, .wakeup_i, .high_voltage_config_i, .timer_src_loop_i, .wakeup_timer_lp_osc_i,
  .precision_input_en_o, .pll_en_o, .core_en_o, .sram_en_o, .flash_if_en_o, .gpio_en_o, .spi_en_o,
  .uart_en_o, .timer_run_o);
`default_nettype wire

// ### verif/tb_power_clock_control.sv
// Purpose: Self-checking bench for power_clock_control
// Assumes: Loop tick every clock cycle except in the no-loop-tick check
// Notes:   Keyed writes are consecutive bus writes
`timescale 1ns/1ps
`default_nettype none
`include "power_clock_consts.vh"
module tb_power_clock_control;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [31:0] addr_i = 32'h0;
  logic [31:0] wdata_i = 32'h0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        wake = 1'b0;
  logic        hv = 1'b0;
  logic [2:0]  src = 3'h5;
  logic        lp = 1'b1;
  logic        tick = 1'b1;
  wire  [31:0] rdata_o;
  wire         prec, xtal, pll, core, sram, flash, gpio, spi, uart, lin, cclk;
  wire  [2:0]  trun, cdiv;
  int          num_errors = 0;
  int          checked = 0;
  int          n;

  power_clock_control u_power_clock_control (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .wakeup_i(wake),
    .high_voltage_config_i(hv), .loop_tick_i(tick), .timer_src_loop_i(src), .wakeup_timer_lp_osc_i(lp),
    .precision_input_en_o(prec), .xtal_en_o(xtal), .pll_en_o(pll), .core_en_o(core), .sram_en_o(sram),
    .flash_if_en_o(flash), .gpio_en_o(gpio), .spi_en_o(spi), .uart_en_o(uart), .lin_wake_en_o(lin),
    .timer_run_o(trun), .core_clk_en_o(cclk), .core_clock_divide_o(cdiv));

  always #5 clk_i = ~clk_i;

  task test_done;
    if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask

  task rd(input logic [31:0] a, input logic [7:0] e);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    chk(rdata_o, {24'h0, e});
  endtask

  task kw(input logic [7:0] d);
    wr(`PWR_PREKEY_ADDR, `PWR_PREKEY_VALUE);
    wr(`PWR_CTRL_ADDR, {24'h0, d});
    wr(`PWR_POSTKEY_ADDR, `PWR_POSTKEY_VALUE);
    repeat (4) @(negedge clk_i);
  endtask

  // Window of 256 ticks holds a whole number of periods for every ratio
  task cnt(input int e);
    n = 0;
    repeat (256) begin
      @(negedge clk_i);
      if (cclk === 1'b1) n++;
    end
    chk(n, e);
  endtask

  initial begin
    repeat (12) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(`PWR_CTRL_ADDR, 8'h79);
    chk({27'h0, prec, xtal, cdiv}, 32'h9);
    wr(`PWR_CTRL_ADDR, 32'h0);
    wr(`PWR_PREKEY_ADDR, `PWR_PREKEY_VALUE);
    wr(32'hffff0400, 32'h0);
    wr(`PWR_CTRL_ADDR, 32'h0);
    wr(`PWR_POSTKEY_ADDR, `PWR_POSTKEY_VALUE);
    // Wrong postwrite key, then wrong prewrite key
    wr(`PWR_PREKEY_ADDR, `PWR_PREKEY_VALUE);
    wr(`PWR_CTRL_ADDR, 32'h0);
    wr(`PWR_POSTKEY_ADDR, 32'h0);
    wr(`PWR_PREKEY_ADDR, 32'h2);
    wr(`PWR_CTRL_ADDR, 32'h0);
    wr(`PWR_POSTKEY_ADDR, `PWR_POSTKEY_VALUE);
    repeat (4) @(negedge clk_i);
    rd(`PWR_CTRL_ADDR, 8'h79);
    rd(`PWR_PREKEY_ADDR, 8'h0);
    hv = 1'b1;
    kw(8'hb9);
    rd(`PWR_CTRL_ADDR, 8'hb9);
    chk({30'h0, prec, xtal}, 32'h2);
    hv = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({31'h0, prec}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      kw(8'h78 | i[7:0]);
      repeat (300) @(negedge clk_i);
      chk({29'h0, cdiv}, i);
      cnt(256 >> i);
    end
    // No loop ticks, no core clock
    tick = 1'b0;
    repeat (2) @(negedge clk_i);
    cnt(0);
    tick = 1'b1;
    kw(8'h71);
    rd(`PWR_CTRL_ADDR, 8'h71);
    chk({29'h0, core, pll, sram}, 32'h3);
    cnt(0);
    kw(8'h41);
    chk({27'h0, pll, sram, trun}, 32'h6);
    lp = 1'b0;
    repeat (3) @(negedge clk_i);
    chk({29'h0, trun}, 32'h2);
    wake = 1'b1;
    @(negedge clk_i);
    wake = 1'b0;
    repeat (3) @(negedge clk_i);
    rd(`PWR_CTRL_ADDR, 8'h79);
    chk({28'h0, core, pll, sram, lin}, 32'hf);
    // Wake-up in the commit cycle must win over the cleared bits
    wr(`PWR_PREKEY_ADDR, `PWR_PREKEY_VALUE);
    wr(`PWR_CTRL_ADDR, 32'h41);
    wr(`PWR_POSTKEY_ADDR, `PWR_POSTKEY_VALUE);
    wake = 1'b1;
    @(negedge clk_i);
    wake = 1'b0;
    repeat (3) @(negedge clk_i);
    rd(`PWR_CTRL_ADDR, 8'h79);
    chk({29'h0, core, pll, sram}, 32'h7);
    test_done;
  end

  initial begin
    #500000;
    num_errors++;
    test_done;
  end
endmodule // tb_power_clock_control
`default_nettype wire
